// [ptb_pkg.sv]
package ptb_pkg;

   // chain geometry
   localparam int PTB_STAGES = 18;
   localparam int PTB_TAP_W = 5;
   localparam int PTB_RATE_W = 3;

   // avalon byte offsets, one word each
   localparam int PTB_ADDR_W = 4;
   localparam logic [3:0] PTB_OFS_CONTROL = 4'h0;
   localparam logic [3:0] PTB_OFS_EVT_STATUS = 4'h4;
   localparam logic [3:0] PTB_OFS_EVT_MASK = 4'h8;

   // timebase_control field positions
   localparam int PTB_BIT_RUN = 1;
   localparam int PTB_BIT_IRQ_EN = 2;
   localparam int PTB_BIT_ACK = 3;
   localparam int PTB_LSB_RATE = 4;
   localparam int PTB_BIT_FLAG = 7;

   // event bits of the sticky status register
   localparam int PTB_NUM_EVT = 2;
   localparam int PTB_EVT_PERIOD = 0;
   localparam int PTB_EVT_OVERRUN = 1;

   // reset values
   localparam logic [2:0] PTB_RST_RATE = 3'h0;
   localparam logic [1:0] PTB_RST_MASK = 2'h0;

   // timing: core clock and oscillator reference
   localparam int PTB_CORE_HZ = 125_000_000;
   localparam int PTB_REF_HZ = 32_768;
   localparam int PTB_REF_DIV = PTB_CORE_HZ / PTB_REF_HZ;

   // tap bit per rate code; period is two to the (tap + 1)
   localparam logic [4:0] PTB_TAP_R0 = 5'h11; // 262144
   localparam logic [4:0] PTB_TAP_R1 = 5'h10; // 131072
   localparam logic [4:0] PTB_TAP_R2 = 5'h0f; // 65536
   localparam logic [4:0] PTB_TAP_R3 = 5'h0e; // 32768
   localparam logic [4:0] PTB_TAP_R4 = 5'h05; // 64
   localparam logic [4:0] PTB_TAP_R5 = 5'h04; // 32
   localparam logic [4:0] PTB_TAP_R6 = 5'h03; // 16
   localparam logic [4:0] PTB_TAP_R7 = 5'h02; // 8

   typedef struct packed {
      logic [2:0] rate_select;
      logic period_irq_enable;
      logic counter_run;
   } ptb_ctrl_t;

   typedef struct packed {
      logic wait_mode;
      logic stop_mode;
      logic stop_osc_keep;
   } ptb_mode_t;

   typedef enum logic {PTB_BUS_IDLE, PTB_BUS_ANSWER} ptb_bus_state_t;

endpackage

// [ptb_divider_chain.sv]
`timescale 1ns/1ps
`default_nettype none
module ptb_divider_chain #(
   parameter int STAGES = 18
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ref_tick_i,
   input wire logic run_i,
   input wire logic [4:0] tap_i,
   output logic period_event_o
);
   logic [STAGES-1:0] stage;
   logic [STAGES:0] carry;

   // carry into stage i: a reference tick with all lower stages at one
   assign carry[0] = ref_tick_i & run_i;

   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi++) begin : g_stage
         assign carry[gi+1] = carry[gi] & stage[gi];
         // each stage toggles on its carry, cleared while stopped
         always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               stage[gi] <= 1'b0;
            end else if (!run_i) begin
               stage[gi] <= 1'b0;
            end else if (carry[gi]) begin
               stage[gi] <= ~stage[gi];
            end
         end
      end
   endgenerate

   // rising edge of the tap bit: first after half a period, then every full one
   assign period_event_o = carry[tap_i] & ~stage[tap_i];
endmodule
`default_nettype wire

// [ptb_event_irq.sv]
`timescale 1ns/1ps
`default_nettype none
module ptb_event_irq #(
   parameter int N = 2
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [N-1:0] set_i,
   input wire logic [N-1:0] clear_i,
   input wire logic mask_we_i,
   input wire logic [N-1:0] mask_d_i,
   output logic [N-1:0] status_o,
   output logic [N-1:0] mask_o,
   output logic irq_o
);
   import ptb_pkg::*;

   logic [N-1:0] next_status;

   // a set in the clearing cycle wins so no event is lost
   assign next_status = set_i | (status_o & ~clear_i);

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_o <= '0;
         mask_o <= PTB_RST_MASK[N-1:0];
      end else begin
         status_o <= next_status;
         if (mask_we_i) begin
            mask_o <= mask_d_i;
         end
      end
   end

   // level output while any unmasked event is pending
   assign irq_o = |(status_o & mask_o);
endmodule
`default_nettype wire

// [ptb_timebase.sv]
// Operation
// RQ1: the timebase is an 18-stage divider chain stepped by the oscillator reference, with eight taps selectable.
// RQ2: while counter_run is clear every chain stage is held at zero.
// RQ3: once counter_run is set the chain advances on each reference tick.
// RQ4: period_flag sets each time the chain overflows at the tap picked by rate_select.
// RQ5: a set period_flag with period_irq_enable set raises the cpu interrupt request.
// RQ6: the first flag after enabling comes at half the period, every later one at a full period.
// RQ7: rate codes 000..111 divide by 262144, 131072, 65536, 32768, 64, 32, 16 and 8.
// RQ8: period_flag is read-only and reads 1 while an event is pending, else 0.
// RQ9: flag_acknowledge is write-only, reads 0, and writing 1 clears period_flag while 0 does nothing.
// RQ10: period_irq_enable is read/write, gates the request and is cleared by reset.
// RQ11: counter_run is read/write, cleared by reset, and toggling it off then on restarts from zero.
// RQ12: software changes rate_select only while counter_run is clear.
// RQ13: in wait mode the chain keeps counting and flagging but the register is not reachable.
// RQ14: in stop mode the chain runs only if the oscillator keep setting is active, and the register is unreachable.
// RQ15: a running chain in stop mode turns its enabled period request into a wake-up event.
// RQ16: the interrupt request stays high as long as both period_flag and period_irq_enable are set.
`timescale 1ns/1ps
`default_nettype none
module ptb_timebase #(
   parameter int STAGES = ptb_pkg::PTB_STAGES,
   parameter int REF_DIV = ptb_pkg::PTB_REF_DIV
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // avalon-mm slave
   input wire logic [ptb_pkg::PTB_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // power modes from the system
   input wire ptb_pkg::ptb_mode_t mode_i,
   // interrupt and wake-up
   output logic period_irq_o,
   output logic stop_wakeup_o,
   output logic evt_irq_o
);
   import ptb_pkg::*;

   // refuse geometries the tap table cannot serve
   generate
      if (STAGES < PTB_STAGES) begin : g_bad_stages
         $error("chain needs at least 18 stages");
      end
      if (REF_DIV < 1) begin : g_bad_div
         $error("reference divider must be at least 1");
      end
   endgenerate

   localparam int DIV_W = (REF_DIV > 1) ? $clog2(REF_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_DIV - 1);

   // address decode shared by read and write paths
   function automatic logic hit(input logic [PTB_ADDR_W-1:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   // rate code to tap bit
   function automatic logic [PTB_TAP_W-1:0] tap_of(input logic [2:0] r);
      case (r)
         3'h0: tap_of = PTB_TAP_R0;
         3'h1: tap_of = PTB_TAP_R1;
         3'h2: tap_of = PTB_TAP_R2;
         3'h3: tap_of = PTB_TAP_R3;
         3'h4: tap_of = PTB_TAP_R4;
         3'h5: tap_of = PTB_TAP_R5;
         3'h6: tap_of = PTB_TAP_R6;
         default: tap_of = PTB_TAP_R7;
      endcase
   endfunction

   ptb_ctrl_t ctrl;
   ptb_ctrl_t next_ctrl;
   ptb_bus_state_t bus_state;
   ptb_bus_state_t next_bus_state;
   logic period_flag;
   logic next_period_flag;
   logic [DIV_W-1:0] ref_cnt;
   logic ref_tick;
   logic osc_halted;
   logic period_event;
   logic bus_req;
   logic bus_commit;
   logic reg_open;
   logic wr_ok;
   logic wr_ctrl;
   logic wr_status;
   logic wr_mask;
   logic ack_clear;
   logic [7:0] ctrl_rd;
   logic [31:0] rd_mux;
   logic [PTB_NUM_EVT-1:0] evt_set;
   logic [PTB_NUM_EVT-1:0] evt_clear;
   logic [PTB_NUM_EVT-1:0] evt_status;
   logic [PTB_NUM_EVT-1:0] evt_mask;

   // oscillator stops in stop mode unless kept running
   assign osc_halted = mode_i.stop_mode & ~mode_i.stop_osc_keep; // [RQ14]

   // reference tick divider; one-cycle enable per reference period
   assign ref_tick = ~osc_halted & (ref_cnt == DIV_LAST); // [RQ13] [RQ14]

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ref_cnt <= '0;
      end else if (!osc_halted) begin
         ref_cnt <= ref_tick ? '0 : ref_cnt + 1'b1;
      end
   end

   // divider chain with tap selection
   ptb_divider_chain #(
      .STAGES(STAGES)
   ) u_chain (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .ref_tick_i(ref_tick), // [RQ1] [RQ3]
      .run_i(ctrl.counter_run), // [RQ2] [RQ11]
      .tap_i(tap_of(ctrl.rate_select)), // [RQ4] [RQ6] [RQ7]
      .period_event_o(period_event)
   );

   // bus handshake: one wait cycle, then the answer
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & (bus_state == PTB_BUS_IDLE);
   assign bus_commit = bus_req & (bus_state == PTB_BUS_ANSWER);

   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         PTB_BUS_IDLE: begin
            if (bus_req) begin
               next_bus_state = PTB_BUS_ANSWER;
            end
         end
         PTB_BUS_ANSWER: begin
            next_bus_state = PTB_BUS_IDLE;
         end
         default: begin
            next_bus_state = PTB_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_state <= PTB_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // registers are sealed off while the cpu sleeps; accesses still complete
   assign reg_open = ~mode_i.wait_mode & ~mode_i.stop_mode; // [RQ13] [RQ14]
   assign wr_ok = bus_commit & avs_write_i & reg_open & avs_byteenable_i[0];
   assign wr_ctrl = wr_ok & hit(avs_address_i, PTB_OFS_CONTROL);
   assign wr_status = wr_ok & hit(avs_address_i, PTB_OFS_EVT_STATUS);
   assign wr_mask = wr_ok & hit(avs_address_i, PTB_OFS_EVT_MASK);

   // writing one to the acknowledge bit clears the flag, zero does nothing
   assign ack_clear = wr_ctrl & avs_writedata_i[PTB_BIT_ACK]; // [RQ9]

   // control fields; rate is taken as written, software keeps it still while running
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl.counter_run = avs_writedata_i[PTB_BIT_RUN]; // [RQ11]
         next_ctrl.period_irq_enable = avs_writedata_i[PTB_BIT_IRQ_EN]; // [RQ10]
         next_ctrl.rate_select = avs_writedata_i[PTB_LSB_RATE +: PTB_RATE_W]; // [RQ12]
      end
   end

   // flag: an overflow in the acknowledge cycle wins over the clear
   assign next_period_flag = period_event | (period_flag & ~ack_clear); // [RQ4] [RQ9]

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl.counter_run <= 1'b0; // [RQ11]
         ctrl.period_irq_enable <= 1'b0; // [RQ10]
         ctrl.rate_select <= PTB_RST_RATE;
         period_flag <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         period_flag <= next_period_flag;
      end
   end

   // level request while flag and enable are both set
   assign period_irq_o = period_flag & ctrl.period_irq_enable; // [RQ5] [RQ10] [RQ16]

   // in stop the same request is the wake-up; with the osc halted only a flag already pending raises it
   assign stop_wakeup_o = mode_i.stop_mode & period_irq_o; // [RQ15]

   // sticky events: each overflow, and an overflow landing on a pending flag
   assign evt_set[PTB_EVT_PERIOD] = period_event;
   assign evt_set[PTB_EVT_OVERRUN] = period_event & period_flag;
   assign evt_clear = wr_status ? avs_writedata_i[PTB_NUM_EVT-1:0] : '0;

   ptb_event_irq #(
      .N(PTB_NUM_EVT)
   ) u_evt (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(evt_set),
      .clear_i(evt_clear),
      .mask_we_i(wr_mask),
      .mask_d_i(avs_writedata_i[PTB_NUM_EVT-1:0]),
      .status_o(evt_status),
      .mask_o(evt_mask),
      .irq_o(evt_irq_o)
   );

   // control read image; acknowledge and bit 0 always read zero
   always_comb begin
      ctrl_rd = 8'h00;
      ctrl_rd[PTB_BIT_FLAG] = period_flag; // [RQ8]
      ctrl_rd[PTB_LSB_RATE +: PTB_RATE_W] = ctrl.rate_select;
      ctrl_rd[PTB_BIT_ACK] = 1'b0; // [RQ9]
      ctrl_rd[PTB_BIT_IRQ_EN] = ctrl.period_irq_enable; // [RQ10]
      ctrl_rd[PTB_BIT_RUN] = ctrl.counter_run; // [RQ11]
   end

   // read select; unmapped offsets and sealed registers read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (reg_open) begin
         if (hit(avs_address_i, PTB_OFS_CONTROL)) begin
            rd_mux[7:0] = ctrl_rd;
         end else if (hit(avs_address_i, PTB_OFS_EVT_STATUS)) begin
            rd_mux[PTB_NUM_EVT-1:0] = evt_status;
         end else if (hit(avs_address_i, PTB_OFS_EVT_MASK)) begin
            rd_mux[PTB_NUM_EVT-1:0] = evt_mask;
         end
      end
   end

   // read data captured in the wait cycle, shown with waitrequest low
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && bus_state == PTB_BUS_IDLE) begin
         avs_readdata_o <= rd_mux;
      end
   end
endmodule
`default_nettype wire

// [ptb_timebase_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ptb_timebase_props
   import ptb_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [PTB_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire ptb_mode_t mode_i,
   input wire logic period_irq_o,
   input wire logic stop_wakeup_o,
   input wire logic evt_irq_o
);
   logic run_q;
   logic ie_q;
   logic [2:0] rate_q;
   // control access only lands outside wait and stop
   wire awake = !mode_i.wait_mode && !mode_i.stop_mode;
   wire ctl_hit = (avs_address_i == PTB_OFS_CONTROL) && awake;
   wire done = !avs_waitrequest_o;
   wire wr_done = avs_write_i && done && avs_byteenable_i[0] && ctl_hit;
   wire rd_done = avs_read_i && done && ctl_hit;
   wire frz = mode_i.stop_mode && !mode_i.stop_osc_keep;
   // shadow of the software bits, fed by committed writes
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         run_q <= 1'b0;
         ie_q <= 1'b0;
         rate_q <= 3'h0;
      end else if (wr_done) begin
         run_q <= avs_writedata_i[PTB_BIT_RUN];
         ie_q <= avs_writedata_i[PTB_BIT_IRQ_EN];
         rate_q <= avs_writedata_i[PTB_LSB_RATE +: 3];
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_req_first;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_answer;
      !avs_waitrequest_o;
   endsequence
   AST_WAIT_FIRST: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
      else $error("no wait cycle on a fresh request");
   AST_ONE_WAIT: assert property (s_req_first |=> s_answer)
      else $error("answer not in second cycle");
   AST_READ_CTRL: assert property (rd_done |->
      avs_readdata_o[6:0] == {rate_q, 1'b0, ie_q, run_q, 1'b0} && avs_readdata_o[31:8] == 24'h0)
      else $error("control readback wrong");
   AST_READ_FLAG: assert property (rd_done && ie_q |-> avs_readdata_o[7] == $past(period_irq_o))
      else $error("flag readback disagrees with request");
   AST_BLOCKED: assert property (avs_read_i && done && !awake && $past(!awake) |->
      avs_readdata_o == 32'h0) else $error("register reachable in low power");
   AST_IRQ_HOLD: assert property (period_irq_o && !wr_done |=> period_irq_o)
      else $error("request dropped without a write");
   AST_IE_OFF: assert property (wr_done && !avs_writedata_i[PTB_BIT_IRQ_EN] |=> !period_irq_o)
      else $error("request with enable cleared");
   AST_HALTED: assert property (!run_q && !$past(run_q) && ie_q && !period_irq_o && !wr_done
      |=> !period_irq_o) else $error("flag set while chain halted");
   AST_STOP_FROZEN: assert property (frz && $past(frz) && $past(frz, 2) && !period_irq_o
      |=> !period_irq_o) else $error("chain ran in stop without oscillator");
   AST_WAKE: assert property (stop_wakeup_o == (mode_i.stop_mode && period_irq_o))
      else $error("wake-up not tied to stop and request");
   // the event request only falls on a completed write; overflows still set events
   AST_EVT_HOLD: assert property (evt_irq_o && !(avs_write_i && done) |=> evt_irq_o)
      else $error("event request dropped without a write");
endmodule
bind ptb_timebase ptb_timebase_props u_props (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .mode_i(mode_i), .period_irq_o(period_irq_o),
   .stop_wakeup_o(stop_wakeup_o), .evt_irq_o(evt_irq_o));
`default_nettype wire

// [ptb_timebase_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ptb_timebase_tb;
   import ptb_pkg::*;
   logic clk, rst, rd, wr, wreq, pirq, wake, eirq;
   logic [3:0] adr, be;
   logic [31:0] wd, rdat, q, rv;
   ptb_mode_t mode;
   int n_fail, num_checks, seed, t0;
   ptb_timebase #(.STAGES(PTB_STAGES), .REF_DIV(1)) dut (.core_clk_i(clk), .sys_rst_i(rst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .mode_i(mode),
      .period_irq_o(pirq), .stop_wakeup_o(wake), .evt_irq_o(eirq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] ctl(input logic [2:0] r, input logic ie, run, ack);
      return {25'h0, r, ack, ie, run, 1'b0};
   endfunction
   // reference clocks per period for each rate code
   function automatic int period(input logic [2:0] r);
      return r[2] ? (64 >> r[1:0]) : (262144 >> r[1:0]);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // one transfer, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      // values seen here are still those of the edge, before its updates
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      // let the commit settle before callers look at outputs
      @(negedge clk);
   endtask
   task automatic wait_irq(input int lim);
      int k;
      k = 0;
      while (pirq !== 1'b1 && k < lim) begin
         @(negedge clk);
         k++;
      end
   endtask
   // restart from zero, check half period first, then a full period
   task automatic meas(input logic [2:0] r);
      int h;
      h = period(r) / 2;
      bus(0, PTB_OFS_CONTROL, 0);
      bus(1, PTB_OFS_CONTROL, (q & 32'h74) | 32'h8); // stop at the old rate
      bus(1, PTB_OFS_CONTROL, ctl(r, 1, 1, 1));
      t0 = $time;
      wait_irq(200);
      chk("first", 1, ($time - t0) / 8 >= h - 1 && ($time - t0) / 8 <= h + 2);
      t0 = $time;
      if (r == 3'h4) begin
         bus(0, PTB_OFS_CONTROL, 0);
         chk("flag", ctl(r, 1, 1, 0) | 32'h80, q);
         bus(1, PTB_OFS_CONTROL, ctl(r, 1, 1, 0));
         chk("ack0", 1, pirq);
      end
      bus(1, PTB_OFS_CONTROL, ctl(r, 1, 1, 1));
      chk("ack1", 0, pirq);
      wait_irq(200);
      chk("period", period(r), ($time - t0) / 8);
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end
   initial begin
      seed = 32'h7553e0d7;
      rst = 1'b1;
      {rd, wr, adr, wd, mode} = '0;
      be = 4'hf;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // reset values of all three registers
      for (int a = 0; a < 12; a += 4) begin
         bus(0, a[3:0], 0);
         chk("reset", 0, q);
      end
      for (int i = 0; i < 8; i++) begin
         rv = $random(seed);
         bus(1, PTB_OFS_CONTROL, ctl(rv[2:0], rv[3], 0, rv[4]));
         bus(0, PTB_OFS_CONTROL, 0);
         chk("rwback", ctl(rv[2:0], rv[3], 0, 0), q);
      end
      @(posedge clk) be <= 4'h0;
      bus(1, PTB_OFS_CONTROL, ctl(~rv[2:0], 1, 0, 0));
      @(posedge clk) be <= 4'hf;
      bus(0, PTB_OFS_CONTROL, 0);
      chk("no_be", ctl(rv[2:0], rv[3], 0, 0), q);
      bus(1, 4'hc, 32'hffffffff);
      bus(0, 4'hc, 0);
      chk("unmapped", 0, q);
      for (int r = 7; r >= 4; r--) meas(r[2:0]);
      // flag pends with the request gated off
      bus(1, PTB_OFS_CONTROL, ctl(4, 0, 0, 1));
      bus(1, PTB_OFS_CONTROL, ctl(7, 0, 1, 1));
      repeat (20) @(negedge clk);
      chk("gated", 0, pirq);
      bus(1, PTB_OFS_CONTROL, ctl(7, 1, 1, 0));
      chk("level", 1, pirq);
      bus(1, PTB_OFS_CONTROL, ctl(7, 1, 0, 1));
      bus(0, PTB_OFS_EVT_STATUS, 0);
      chk("evt_st", 32'h3, q);
      chk("evt_off", 0, eirq);
      bus(1, PTB_OFS_EVT_MASK, 32'h1);
      chk("evt_on", 1, eirq);
      bus(1, PTB_OFS_EVT_STATUS, 32'h3);
      chk("evt_clr", 0, eirq);
      bus(0, PTB_OFS_EVT_STATUS, 0);
      chk("evt_st0", 0, q);
      // wait mode: counting goes on, register shut away
      bus(1, PTB_OFS_CONTROL, ctl(7, 1, 1, 1));
      @(posedge clk) mode <= 3'b100;
      bus(1, PTB_OFS_CONTROL, 0);
      bus(0, PTB_OFS_CONTROL, 0);
      chk("wait_rd", 0, q);
      repeat (10) @(negedge clk);
      chk("wait_run", 1, pirq);
      @(posedge clk) mode <= 3'b000;
      bus(0, PTB_OFS_CONTROL, 0);
      chk("wait_keep", ctl(7, 1, 1, 0) | 32'h80, q);
      // stop mode, oscillator off then kept
      bus(1, PTB_OFS_CONTROL, ctl(7, 1, 0, 1));
      bus(1, PTB_OFS_CONTROL, ctl(4, 1, 1, 1));
      @(posedge clk) mode <= 3'b010;
      repeat (100) @(negedge clk);
      chk("stop_halt", 0, pirq);
      @(posedge clk) mode <= 3'b011;
      repeat (40) @(negedge clk);
      chk("stop_run", 1, pirq);
      chk("wakeup", 1, wake);
      bus(0, PTB_OFS_CONTROL, 0);
      chk("stop_rd", 0, q);
      // reset in mid-run clears control and every request
      @(posedge clk);
      rst <= 1'b1;
      mode <= 3'b000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(0, PTB_OFS_CONTROL, 0);
      chk("rst_ctl", 0, q);
      chk("rst_irq", 0, {pirq, wake, eirq});
      conclude();
   end
endmodule
`default_nettype wire
